// file: hdl/pfm_top.sv
// Pulse frequency meter with range scaling, limit handling and register port
//------------------------------------------------------------
// Behaviour
// [RULE1] Over-range error above upper range plus 5%, or 21.0 mA on 4-20 mA
// [RULE2] On 4-20 mA input, under-range error below 3.6 mA always
// [RULE3] No under-range detection below 0 V or 0 mA
// [RULE4] First-order low-pass smoothing, time 0.01 to 2.00 s
// [RULE5] With 0-50 mV input operator should choose smoothing 0.2 or more
// [RULE6] Pulse source: logic level, sinking contact pull-up, sourcing pull-down
// [RULE7] Low frequency setting shows low display value; display span -1999..9999
// [RULE8] High setting shows high value, linear between; frequency 0..9999, high>=low
// [RULE9] Limit off: scaled values continue beyond range up to measuring limit
// [RULE10] Error limit mode: error when frequency leaves configured range
// [RULE11] Clamp limit mode: show low or high display value outside range
// [RULE12] Over-range error above 10 kHz in every limit mode
// [RULE13] Speed mode divides pulses by prescale factor 1 to 1000
// [RULE14] Configured values are stored when the configuration reset happens
// [RULE15] Contacts on sinking input must be bounce-free, no debouncing here
// [RULE16] Contacts with external circuitry must be configured as logic level
//------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "pfm_defs.svh"
module pfm_top #(
	parameter int GATE_CYCLES = `PFM_GATE_CYC,
	parameter int TICK_CYCLES = `PFM_TICK_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_pulse_in,
	input wire logic [15:0] i_ana_permille,
	input wire logic [15:0] i_loop_ua,
	output logic o_pullup_en,
	output logic o_pulldown_en,
	output logic signed [15:0] o_display,
	output logic [2:0] o_decimal_point,
	output logic o_err_over,
	output logic o_err_under,
	output logic o_irq
);
	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	function automatic logic signed [31:0] clamp_s(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic signed [31:0] scale(input logic signed [31:0] f,
		input logic signed [31:0] flo, input logic signed [31:0] fhi,
		input logic signed [31:0] dlo, input logic signed [31:0] dhi);
		if (fhi == flo) begin
			scale = dlo;
		end else begin
			scale = dlo + ((f - flo) * (dhi - dlo)) / (fhi - flo);
		end
	endfunction

	//------------------------------------------------------------
	// Staged configuration written by software
	//------------------------------------------------------------
	logic [8:0] ctrl_r;
	logic [13:0] frequency_mode_range_low_r;
	logic [13:0] frequency_mode_range_high_r;
	logic [15:0] display_low_value_r;
	logic [15:0] display_high_value_r;
	logic [7:0] smoothing_time_r;
	logic [9:0] divisor_r;
	logic [3:0] status_r;
	logic [3:0] mask_r;
	logic wr_commit;
	logic wr_status;

	assign wr_commit = i_wr && (i_addr == `PFM_REG_COMMIT);
	assign wr_status = i_wr && (i_addr == `PFM_REG_STATUS);

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ctrl_r <= `PFM_CTRL_RST;
			frequency_mode_range_low_r <= `PFM_FREQUENCY_MODE_RANGE_LOW_RST;
			frequency_mode_range_high_r <= `PFM_FR_HI_RST;
			display_low_value_r <= `PFM_DISPLAY_LOW_VALUE_RST;
			display_high_value_r <= `PFM_DISPLAY_HIGH_VALUE_RST;
			smoothing_time_r <= `PFM_SMOOTH_RST;
			divisor_r <= `PFM_DIV_RST;
			mask_r <= 4'h0;
		end else if (i_wr) begin
			unique case (i_addr)
				`PFM_REG_CTRL: ctrl_r <= i_wdata[8:0];
				`PFM_REG_FREQUENCY_MODE_RANGE_LOW: frequency_mode_range_low_r <= i_wdata[13:0];
				`PFM_REG_FR_HI: frequency_mode_range_high_r <= i_wdata[13:0];
				`PFM_REG_DISPLAY_LOW_VALUE: display_low_value_r <= i_wdata[15:0];
				`PFM_REG_DISPLAY_HIGH_VALUE: display_high_value_r <= i_wdata[15:0];
				`PFM_REG_SMOOTH: smoothing_time_r <= i_wdata[7:0];
				`PFM_REG_DIVISOR: divisor_r <= i_wdata[9:0];
				`PFM_REG_MASK: mask_r <= i_wdata[3:0];
				default: ;
			endcase
		end
	end

	//------------------------------------------------------------
	// Active configuration, taken on the configuration reset
	//------------------------------------------------------------
	logic [8:0] act_ctrl_r;
	logic signed [31:0] act_flo_r;
	logic signed [31:0] act_fhi_r;
	logic signed [31:0] act_dlo_r;
	logic signed [31:0] act_dhi_r;
	logic [7:0] act_smooth_r;
	logic [9:0] act_div_r;
	logic signed [31:0] new_flo;
	logic signed [31:0] new_fhi;
	logic signed [31:0] new_smooth;
	logic signed [31:0] new_div;

	assign new_flo = clamp_s({18'h0, frequency_mode_range_low_r}, 32'sd0, `PFM_FSET_MAX);
	assign new_fhi = clamp_s({18'h0, frequency_mode_range_high_r}, new_flo, `PFM_FSET_MAX);
	assign new_smooth = clamp_s({24'h0, smoothing_time_r}, `PFM_SMOOTH_MIN, `PFM_SMOOTH_MAX);
	assign new_div = clamp_s({22'h0, divisor_r}, `PFM_DIV_MIN, `PFM_DIV_MAX);

	// [RULE14] Store on reset
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			act_ctrl_r <= `PFM_CTRL_RST;
			act_flo_r <= {18'h0, `PFM_FREQUENCY_MODE_RANGE_LOW_RST};
			act_fhi_r <= {18'h0, `PFM_FR_HI_RST};
			act_dlo_r <= {{16{1'b0}}, `PFM_DISPLAY_LOW_VALUE_RST};
			act_dhi_r <= {{16{1'b0}}, `PFM_DISPLAY_HIGH_VALUE_RST};
			act_smooth_r <= `PFM_SMOOTH_RST;
			act_div_r <= `PFM_DIV_RST;
		end else if (wr_commit) begin
			act_ctrl_r <= ctrl_r;
			act_flo_r <= new_flo;
			// [RULE8] High kept at or above low
			act_fhi_r <= new_fhi;
			// [RULE7] Display span limits
			act_dlo_r <= clamp_s({{16{display_low_value_r[15]}}, display_low_value_r},
				`PFM_DISP_MIN, `PFM_DISP_MAX);
			act_dhi_r <= clamp_s({{16{display_high_value_r[15]}}, display_high_value_r},
				`PFM_DISP_MIN, `PFM_DISP_MAX);
			// [RULE4] Smoothing 1..200 ticks of 10 ms
			act_smooth_r <= new_smooth[7:0];
			// [RULE13] Prescale 1..1000
			act_div_r <= new_div[9:0];
		end
	end

	pfm_pkg::pfm_mode_e mode;
	pfm_pkg::pfm_src_e input_source_select;
	pfm_pkg::pfm_limit_e limit_error_mode;
	logic pulse_mode;
	assign mode = pfm_pkg::pfm_mode_e'(act_ctrl_r[`PFM_CTRL_MODE]);
	assign input_source_select = pfm_pkg::pfm_src_e'(act_ctrl_r[`PFM_CTRL_SRC]);
	assign limit_error_mode = pfm_pkg::pfm_limit_e'(act_ctrl_r[`PFM_CTRL_LIMIT]);
	assign pulse_mode = (mode == pfm_pkg::PFM_MODE_FREQUENCY_MODE) || (mode == pfm_pkg::PFM_MODE_SPEED);
	assign o_decimal_point = act_ctrl_r[`PFM_CTRL_DP];

	//------------------------------------------------------------
	// Pulse input conditioning and prescaler
	//------------------------------------------------------------
	logic pulse_level;
	logic pulse_prev_r;
	logic pulse_edge;
	logic [9:0] div_cnt_r;
	logic pulse_ev;

	// [RULE6] Sinking contact idles high via pull-up, closing pulls low
	assign o_pullup_en = (input_source_select == pfm_pkg::PFM_SRC_SINK);
	assign o_pulldown_en = (input_source_select == pfm_pkg::PFM_SRC_SOURCE);
	assign pulse_level = o_pullup_en ? ~i_pulse_in : i_pulse_in;

	// [RULE15] Every rising edge counts, bounce is not filtered
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pulse_prev_r <= 1'b0;
		end else begin
			pulse_prev_r <= pulse_level;
		end
	end
	assign pulse_edge = pulse_level && !pulse_prev_r && pulse_mode;

	// [RULE13] Speed mode passes one event per act_div_r edges
	always_ff @(posedge i_core_clk) begin
		if (i_rst || wr_commit) begin
			div_cnt_r <= 10'h000;
		end else if (pulse_edge && mode == pfm_pkg::PFM_MODE_SPEED) begin
			div_cnt_r <= (div_cnt_r == act_div_r - 10'h001) ? 10'h000 : div_cnt_r + 10'h001;
		end
	end
	assign pulse_ev = (mode == pfm_pkg::PFM_MODE_SPEED) ?
		(pulse_edge && div_cnt_r == act_div_r - 10'h001) : pulse_edge;

	//------------------------------------------------------------
	// Gate and filter tick dividers
	//------------------------------------------------------------
	logic [31:0] gate_cnt_r;
	logic [31:0] tick_cnt_r;
	logic gate_end;
	logic tick;
	assign gate_end = (gate_cnt_r == 32'(GATE_CYCLES - 1));
	assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

	always_ff @(posedge i_core_clk) begin
		if (i_rst || gate_end) begin
			gate_cnt_r <= 32'h0;
		end else begin
			gate_cnt_r <= gate_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst || tick) begin
			tick_cnt_r <= 32'h0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end

	//------------------------------------------------------------
	// Frequency measurement over a one second gate
	//------------------------------------------------------------
	logic [23:0] pulse_cnt_r;
	logic [23:0] frequency_mode_raw_r;
	logic [23:0] cnt_inc;
	assign cnt_inc = (pulse_ev && pulse_cnt_r != 24'hffffff) ? pulse_cnt_r + 24'h1 : pulse_cnt_r;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pulse_cnt_r <= 24'h0;
			frequency_mode_raw_r <= 24'h0;
		end else if (gate_end) begin
			pulse_cnt_r <= 24'h0;
			frequency_mode_raw_r <= cnt_inc;
		end else begin
			pulse_cnt_r <= cnt_inc;
		end
	end

	logic [23:0] frequency_mode_filt;
	// [RULE4] Smoothing of the measured frequency
	pfm_lowpass #(
		.WIDTH(24)
	) u_lowpass (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_step(tick),
		.i_load(wr_commit),
		.i_sample(frequency_mode_raw_r),
		.i_steps(act_smooth_r),
		.o_value(frequency_mode_filt)
	);

	//------------------------------------------------------------
	// Scaling and limit handling
	//------------------------------------------------------------
	logic signed [31:0] ff;
	logic signed [31:0] scaled;
	logic above_rng;
	logic below_rng;
	logic frequency_mode_over;
	logic ana_over;
	logic ana_under;
	logic signed [31:0] disp_nxt;
	logic over_nxt;
	logic under_nxt;

	assign ff = clamp_s({8'h0, frequency_mode_filt}, 32'sd0, `PFM_FREQUENCY_MODE_CLIP);
	// [RULE7] [RULE8] Linear map from frequency range onto display range
	assign scaled = scale(ff, act_flo_r, act_fhi_r, act_dlo_r, act_dhi_r);
	assign above_rng = ff > act_fhi_r;
	assign below_rng = ff < act_flo_r;
	// [RULE12] Over 10 kHz is an error in every limit mode
	assign frequency_mode_over = pulse_mode && ({8'h0, frequency_mode_raw_r} > `PFM_FREQUENCY_MODE_ERR_HZ);
	// [RULE1] 5 % above upper range, or 21.0 mA on the loop input
	// [RULE2] Loop under 3.6 mA; [RULE3] no check below zero otherwise
	always_comb begin
		ana_over = 1'b0;
		ana_under = 1'b0;
		if (mode == pfm_pkg::PFM_MODE_LOOP) begin
			ana_over = i_loop_ua > `PFM_LOOP_OVER_UA;
			ana_under = i_loop_ua < `PFM_LOOP_UNDER_UA;
		end else if (mode == pfm_pkg::PFM_MODE_VOLT) begin
			ana_over = i_ana_permille > `PFM_ANA_OVER_PM;
		end
	end

	always_comb begin
		disp_nxt = clamp_s(scaled, `PFM_DISP_MIN, `PFM_DISP_MAX);
		over_nxt = frequency_mode_over || ana_over;
		under_nxt = ana_under;
		if (mode == pfm_pkg::PFM_MODE_FREQUENCY_MODE) begin
			unique case (limit_error_mode)
				// [RULE10] Error outside the configured range
				pfm_pkg::PFM_LIM_ERR: begin
					over_nxt = over_nxt || above_rng;
					under_nxt = under_nxt || below_rng;
				end
				// [RULE11] Clamp to the display end values
				pfm_pkg::PFM_LIM_CLAMP: begin
					if (above_rng) begin
						disp_nxt = act_dhi_r;
					end else if (below_rng) begin
						disp_nxt = act_dlo_r;
					end
				end
				// [RULE9] Off: keep scaling up to the measuring limit
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_display <= 16'h0000;
			o_err_over <= 1'b0;
			o_err_under <= 1'b0;
		end else begin
			o_display <= disp_nxt[15:0];
			o_err_over <= over_nxt;
			o_err_under <= under_nxt;
		end
	end

	//------------------------------------------------------------
	// Interrupt status, write one to clear, set wins
	//------------------------------------------------------------
	logic [3:0] st_set;
	assign st_set = {wr_commit, under_nxt && !o_err_under, over_nxt && !o_err_over, gate_end};

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			status_r <= 4'h0;
		end else begin
			status_r <= (status_r & ~(wr_status ? i_wdata[3:0] : 4'h0)) | st_set;
		end
	end
	assign o_irq = |(status_r & mask_r);

	//------------------------------------------------------------
	// Read port, data one cycle after the strobe
	//------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h0;
		end else if (i_rd) begin
			unique case (i_addr)
				`PFM_REG_CTRL: o_rdata <= {23'h0, ctrl_r};
				`PFM_REG_FREQUENCY_MODE_RANGE_LOW: o_rdata <= {18'h0, frequency_mode_range_low_r};
				`PFM_REG_FR_HI: o_rdata <= {18'h0, frequency_mode_range_high_r};
				`PFM_REG_DISPLAY_LOW_VALUE: o_rdata <= {16'h0, display_low_value_r};
				`PFM_REG_DISPLAY_HIGH_VALUE: o_rdata <= {16'h0, display_high_value_r};
				`PFM_REG_SMOOTH: o_rdata <= {24'h0, smoothing_time_r};
				`PFM_REG_DIVISOR: o_rdata <= {22'h0, divisor_r};
				`PFM_REG_STATUS: o_rdata <= {28'h0, status_r};
				`PFM_REG_MASK: o_rdata <= {28'h0, mask_r};
				`PFM_REG_FREQUENCY_MODE: o_rdata <= {8'h0, frequency_mode_filt};
				`PFM_REG_DISPLAY: o_rdata <= {16'h0, o_display};
				`PFM_REG_ERR: o_rdata <= {30'h0, o_err_under, o_err_over};
				default: o_rdata <= 32'h0;
			endcase
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence s_commit;
		i_wr && i_addr == `PFM_REG_COMMIT;
	endsequence

	a_loop_over_err: assert property (mode == pfm_pkg::PFM_MODE_LOOP && i_loop_ua > 16'd21000 // [RULE1]
		|=> o_err_over) else $error("loop over 21 mA not flagged");
	a_loop_under_err: assert property (mode == pfm_pkg::PFM_MODE_LOOP && i_loop_ua < 16'd3600 // [RULE2]
		|=> o_err_under) else $error("loop under 3.6 mA not flagged");
	a_volt_no_under: assert property (mode == pfm_pkg::PFM_MODE_VOLT |=> !o_err_under) // [RULE3]
		else $error("under-range raised on voltage input");
	a_filter_moves: assert property (tick && !wr_commit && {frequency_mode_raw_r, 8'h00} > {frequency_mode_filt, 8'h00} // [RULE4]
		|=> frequency_mode_filt >= $past(frequency_mode_filt)) else $error("filter moved away from input");
	a_pull_exclusive: assert property (!(o_pullup_en && o_pulldown_en)) // [RULE6]
		else $error("pull-up and pull-down both enabled");
	a_scale_low: assert property (limit_error_mode == pfm_pkg::PFM_LIM_OFF && ff == act_flo_r // [RULE7]
		&& !wr_commit |=> o_display == $past(act_dlo_r[15:0])) else $error("low point wrong");
	a_scale_high: assert property (ff == act_fhi_r && act_fhi_r != act_flo_r && !wr_commit // [RULE8]
		|=> o_display == $past(act_dhi_r[15:0])) else $error("high point wrong");
	a_limit_off: assert property (mode == pfm_pkg::PFM_MODE_FREQUENCY_MODE && limit_error_mode == // [RULE9]
		pfm_pkg::PFM_LIM_OFF && !frequency_mode_over && !wr_commit |=> !o_err_over)
		else $error("error raised with limit handling off");
	a_err_range: assert property (mode == pfm_pkg::PFM_MODE_FREQUENCY_MODE && limit_error_mode == // [RULE10]
		pfm_pkg::PFM_LIM_ERR && below_rng && !wr_commit |=> o_err_under)
		else $error("below range not flagged");
	a_clamp_high: assert property (mode == pfm_pkg::PFM_MODE_FREQUENCY_MODE && limit_error_mode == // [RULE11]
		pfm_pkg::PFM_LIM_CLAMP && above_rng && !wr_commit |=> o_display == $past(act_dhi_r[15:0]))
		else $error("clamp to high value failed");
	a_max_frequency_mode: assert property (gate_end && pulse_mode && cnt_inc > 24'd10000 // [RULE12]
		|=> ##1 o_err_over) else $error("over 10 kHz not flagged");
	a_prescale: assert property (mode == pfm_pkg::PFM_MODE_SPEED && act_div_r == 10'd3 // [RULE13]
		&& pulse_ev && !wr_commit |=> !pulse_ev [*3]) else $error("prescale too fast");
	a_cfg_store: assert property (s_commit |=> act_ctrl_r == $past(ctrl_r) // [RULE14]
		&& act_div_r == $past(new_div[9:0])) else $error("configuration not stored");
endmodule
`default_nettype wire

// file: hdl/pfm_defs.svh
// Constants of the pulse frequency meter and scaler
`ifndef PFM_DEFS_SVH
`define PFM_DEFS_SVH
// Timing
`define PFM_CLK_HZ 20000000
`define PFM_TICK_MS 10
`define PFM_GATE_MS 1000
`define PFM_TICK_CYC ((`PFM_CLK_HZ / 1000) * `PFM_TICK_MS)
`define PFM_GATE_CYC ((`PFM_CLK_HZ / 1000) * `PFM_GATE_MS)
// Register offsets
`define PFM_REG_CTRL 8'h00
`define PFM_REG_FREQUENCY_MODE_RANGE_LOW 8'h04
`define PFM_REG_FR_HI 8'h08
`define PFM_REG_DISPLAY_LOW_VALUE 8'h0c
`define PFM_REG_DISPLAY_HIGH_VALUE 8'h10
`define PFM_REG_SMOOTH 8'h14
`define PFM_REG_DIVISOR 8'h18
`define PFM_REG_COMMIT 8'h1c
`define PFM_REG_STATUS 8'h20
`define PFM_REG_MASK 8'h24
`define PFM_REG_FREQUENCY_MODE 8'h28
`define PFM_REG_DISPLAY 8'h2c
`define PFM_REG_ERR 8'h30
// Control fields
`define PFM_CTRL_MODE 1:0
`define PFM_CTRL_SRC 3:2
`define PFM_CTRL_LIMIT 5:4
`define PFM_CTRL_DP 8:6
`define PFM_CTRL_RST 9'h000
// Status bits
`define PFM_ST_NEW 0
`define PFM_ST_OVER 1
`define PFM_ST_UNDER 2
`define PFM_ST_CFG 3
// Limits and reset values
`define PFM_FREQUENCY_MODE_ERR_HZ 32'd10000
`define PFM_FREQUENCY_MODE_CLIP 32'sd20000
`define PFM_ANA_OVER_PM 16'd1050
`define PFM_LOOP_OVER_UA 16'd21000
`define PFM_LOOP_UNDER_UA 16'd3600
`define PFM_FSET_MAX 32'sd9999
`define PFM_DISP_MIN (-32'sd1999)
`define PFM_DISP_MAX 32'sd9999
`define PFM_SMOOTH_MIN 32'sd1
`define PFM_SMOOTH_MAX 32'sd200
`define PFM_DIV_MIN 32'sd1
`define PFM_DIV_MAX 32'sd1000
`define PFM_FREQUENCY_MODE_RANGE_LOW_RST 14'h0000
`define PFM_FR_HI_RST 14'h270f
`define PFM_DISPLAY_LOW_VALUE_RST 16'h0000
`define PFM_DISPLAY_HIGH_VALUE_RST 16'h270f
`define PFM_SMOOTH_RST 8'h01
`define PFM_DIV_RST 10'h001
`endif

// file: hdl/pfm_pkg.sv
// Types of the pulse frequency meter and scaler
`default_nettype none
package pfm_pkg;
	typedef enum logic [1:0] {
		PFM_MODE_FREQUENCY_MODE = 2'h0,
		PFM_MODE_SPEED = 2'h1,
		PFM_MODE_VOLT = 2'h2,
		PFM_MODE_LOOP = 2'h3
	} pfm_mode_e;
	typedef enum logic [1:0] {
		PFM_SRC_LOGIC = 2'h0,
		PFM_SRC_SINK = 2'h1,
		PFM_SRC_SOURCE = 2'h2,
		PFM_SRC_RSVD = 2'h3
	} pfm_src_e;
	typedef enum logic [1:0] {
		PFM_LIM_OFF = 2'h0,
		PFM_LIM_ERR = 2'h1,
		PFM_LIM_CLAMP = 2'h2,
		PFM_LIM_RSVD = 2'h3
	} pfm_limit_e;
endpackage
`default_nettype wire

// file: hdl/pfm_lowpass.sv
// First-order low-pass filter for the measured frequency
`timescale 1ns/10ps
`default_nettype none
module pfm_lowpass #(
	parameter int WIDTH = 24
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_step,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_sample,
	input wire logic [7:0] i_steps,
	output logic [WIDTH-1:0] o_value
);
	logic [WIDTH+7:0] acc_r;
	logic [WIDTH+7:0] target;
	logic [WIDTH+7:0] divisor;
	assign target = {i_sample, 8'h00};
	assign divisor = (i_steps == 8'h00) ? {{WIDTH{1'b0}}, 8'h01} : {{WIDTH{1'b0}}, i_steps};
	assign o_value = acc_r[WIDTH+7:8];
	// Each step closes 1/steps of the gap, time constant is steps ticks
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			acc_r <= '0;
		end else if (i_load) begin
			acc_r <= target;
		end else if (i_step) begin
			if (target >= acc_r) begin
				acc_r <= acc_r + (target - acc_r) / divisor;
			end else begin
				acc_r <= acc_r - (acc_r - target) / divisor;
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/pfm_pulse_src.sv
// Pulse transmitter model driving the frequency input
`timescale 1ns/10ps
`default_nettype none
module pfm_pulse_src (
	input wire logic i_core_clk,
	input wire logic i_run,
	input wire logic [7:0] i_half,
	output logic o_pulse
);
	logic [7:0] cnt_r;
	//------------------------------------------------------------
	// Square wave, i_half cycles per level
	//------------------------------------------------------------
	// clean logic-level edges
	always_ff @(posedge i_core_clk) begin
		if (!i_run) begin
			cnt_r <= 8'h00;
			o_pulse <= 1'b0;
		end else if (cnt_r >= i_half - 8'h01) begin
			cnt_r <= 8'h00;
			o_pulse <= ~o_pulse;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule
`default_nettype wire

// file: verif/pulse_frequency_meter_scaler_test.sv
// Self-checking bench of the pulse frequency meter
`timescale 1ns/10ps
`default_nettype none
`include "pfm_defs.svh"
module pulse_frequency_meter_scaler_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run = 1'b0;
	logic [7:0] half = 8'h02;
	logic [15:0] ana = 16'h0000;
	logic [15:0] loop_ua = 16'h2ee0;
	logic [31:0] rdata, d;
	logic pulse, pu, pd, e_over, e_under, irq;
	logic [2:0] dp;
	logic signed [15:0] disp;
	int fail_count = 0;
	int tests_run = 0;
	initial begin
		forever #25 clk = ~clk;
	end
	pfm_top #(.GATE_CYCLES(20010), .TICK_CYCLES(20)) dut (.i_core_clk(clk), .i_rst(rst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_pulse_in(pulse), .i_ana_permille(ana), .i_loop_ua(loop_ua), .o_pullup_en(pu),
		.o_pulldown_en(pd), .o_display(disp), .o_decimal_point(dp), .o_err_over(e_over),
		.o_err_under(e_under), .o_irq(irq));
	pfm_pulse_src src (.i_core_clk(clk), .i_run(run), .i_half(half), .o_pulse(pulse));
	//------------------------------------------------------------
	// Bus and check helpers
	//------------------------------------------------------------
	task automatic tally_and_finish;
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd32(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic cfg(input logic [31:0] c, fl, fh, dl, dh, dv);
		wr32(`PFM_REG_CTRL, c);
		wr32(`PFM_REG_FREQUENCY_MODE_RANGE_LOW, fl);
		wr32(`PFM_REG_FR_HI, fh);
		wr32(`PFM_REG_DISPLAY_LOW_VALUE, dl);
		wr32(`PFM_REG_DISPLAY_HIGH_VALUE, dh);
		wr32(`PFM_REG_DIVISOR, dv);
		wr32(`PFM_REG_COMMIT, 32'h1);
		repeat (80) @(posedge clk);
	endtask
	// Two gate ends so that one whole gate saw the new pulse stream
	task automatic wait_gate;
		int n;
		repeat (2) begin
			wr32(`PFM_REG_STATUS, 32'h1);
			n = 0;
			d = 32'h0;
			while (d[0] !== 1'b1 && n < 15000) begin
				rd32(`PFM_REG_STATUS, d);
				n++;
			end
			if (n >= 15000) chk(1'b0, "gate end missing");
		end
		repeat (80) @(posedge clk);
	endtask
	task automatic ana_step(input logic [15:0] l, a, input logic eo, eu, input string m);
		@(posedge clk);
		loop_ua <= l;
		ana <= a;
		repeat (3) @(posedge clk);
		#1;
		chk(e_over === eo && e_under === eu, m);
	endtask
	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_regs;
		rd32(`PFM_REG_CTRL, d);
		chk(d === 32'h0, "ctrl reset value");
		rd32(`PFM_REG_FR_HI, d);
		chk(d === 32'h270f, "frequency_mode high reset value");
		rd32(`PFM_REG_DISPLAY_HIGH_VALUE, d);
		chk(d === 32'h270f, "display high reset value");
		rd32(`PFM_REG_SMOOTH, d);
		chk(d === 32'h1, "smoothing reset value");
		rd32(`PFM_REG_DIVISOR, d);
		chk(d === 32'h1, "divisor reset value");
		rd32(8'h3c, d);
		chk(d === 32'h0, "unmapped read");
		wr32(`PFM_REG_FREQUENCY_MODE, 32'h1234);
		rd32(`PFM_REG_FREQUENCY_MODE, d);
		chk(d === 32'h0, "read-only frequency");
		chk(irq === 1'b0 && e_over === 1'b0 && disp === 16'h0000, "outputs after reset");
	endtask
	task automatic t_irq;
		wr32(`PFM_REG_MASK, 32'h0);
		wr32(`PFM_REG_COMMIT, 32'h1);
		rd32(`PFM_REG_STATUS, d);
		chk(d[3] === 1'b1 && irq === 1'b0, "commit flag masked");
		wr32(`PFM_REG_MASK, 32'h8);
		repeat (2) @(posedge clk);
		chk(irq === 1'b1, "irq raised");
		wr32(`PFM_REG_STATUS, 32'h8);
		repeat (2) @(posedge clk);
		chk(irq === 1'b0, "irq cleared");
		wr32(`PFM_REG_MASK, 32'h0);
	endtask
	task automatic t_pulls;
		for (int s = 0; s < 3; s++) begin
			cfg({28'h0, s[1:0], 2'h0}, 32'h0, 32'h270f, 32'h0, 32'h270f, 32'h1);
			chk(pu === (s == 1) && pd === (s == 2), "pull enables");
		end
	endtask
	task automatic t_analog;
		cfg(32'h3, 32'h0, 32'h270f, 32'h0, 32'h270f, 32'h1);
		ana_step(16'h5208, 16'h0, 1'b0, 1'b0, "loop at upper limit");
		ana_step(16'h5209, 16'h0, 1'b1, 1'b0, "loop above upper limit");
		ana_step(16'h0e10, 16'h0, 1'b0, 1'b0, "loop at lower limit");
		ana_step(16'h0e0f, 16'h0, 1'b0, 1'b1, "loop below lower limit");
		// Small-signal input gets smoothing 0.2 s
		wr32(`PFM_REG_SMOOTH, 32'h14);
		cfg(32'h2, 32'h0, 32'h270f, 32'h0, 32'h270f, 32'h1);
		ana_step(16'h0000, 16'h041b, 1'b1, 1'b0, "analog over range");
		ana_step(16'h0000, 16'h0000, 1'b0, 1'b0, "no under range at zero");
		wr32(`PFM_REG_SMOOTH, 32'h1);
	endtask
	task automatic t_map;
		@(posedge clk);
		run <= 1'b1;
		cfg(32'h140, 32'h3e8, 32'h2328, 32'h0000fc18, 32'hbb8, 32'h1);
		wait_gate();
		rd32(`PFM_REG_FREQUENCY_MODE, d);
		chk(d >= 32'h1389 && d <= 32'h138c, "measured frequency");
		chk(disp >= 16'sh3e7 && disp <= 16'sh3eb && dp === 3'h5, "scaled display");
		cfg(32'h0, 32'h3e8, 32'hbb8, 32'h0000fc18, 32'hbb8, 32'h1);
		chk(disp >= 16'sh1b5a && disp <= 16'sh1b60 && e_over === 1'b0, "beyond range");
	endtask
	task automatic t_limits;
		cfg(32'h10, 32'h3e8, 32'hfa0, 32'h0000fc18, 32'hbb8, 32'h1);
		chk(e_over === 1'b1 && e_under === 1'b0, "error above range");
		cfg(32'h10, 32'h1770, 32'h2328, 32'h0000fc18, 32'hbb8, 32'h1);
		chk(e_under === 1'b1 && e_over === 1'b0, "error below range");
		cfg(32'h20, 32'h1770, 32'h2328, 32'h0000fc18, 32'hbb8, 32'h1);
		chk(disp === 16'hfc18 && e_under === 1'b0, "clamp low");
		cfg(32'h20, 32'h3e8, 32'hfa0, 32'h0000fc18, 32'hbb8, 32'h1);
		chk(disp === 16'h0bb8 && e_over === 1'b0, "clamp high");
	endtask
	task automatic t_speed;
		cfg(32'h1, 32'h0, 32'h270f, 32'h0, 32'h270f, 32'h3);
		wait_gate();
		rd32(`PFM_REG_FREQUENCY_MODE, d);
		chk(d >= 32'h681 && d <= 32'h686, "divided pulses");
		chk(disp >= 16'sh681 && disp <= 16'sh686, "speed display");
	endtask
	task automatic t_fast;
		@(posedge clk);
		half <= 8'h01;
		cfg(32'h20, 32'h0, 32'h270f, 32'h0, 32'h270f, 32'h1);
		wait_gate();
		chk(e_over === 1'b1, "over 10 kHz");
		rd32(`PFM_REG_FREQUENCY_MODE, d);
		chk(d >= 32'h2713 && d <= 32'h2717, "fast frequency");
	endtask
	//------------------------------------------------------------
	// Sequence and watchdog
	//------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_irq();
		t_pulls();
		t_analog();
		t_map();
		t_limits();
		t_speed();
		t_fast();
		tally_and_finish();
	end
	initial begin
		repeat (150000) @(posedge clk);
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
